// ---- rtl/clk_ratio_pkg.sv ----
// Shared constants and carrier types for the system clock ratio block
package clk_ratio_pkg;

  // ----------------------------------------------------------------
  // Register bus shape and offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int        ADDR_W          = 8;
  localparam int        DATA_W          = 32;
  localparam logic [7:0] OFS_CFG_STATUS  = 8'h00;
  localparam logic [7:0] OFS_RATIO       = 8'h04;
  localparam logic [7:0] OFS_UNIT_CLK    = 8'h08;
  localparam logic [7:0] OFS_LB_RATIO    = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STS_CFG_LSB      = 0;   // Latched config word, 8 bits
  localparam int STS_STRAP_BIT    = 8;
  localparam int STS_AGENT_BIT    = 9;
  localparam int STS_RSVD_BIT     = 10;
  localparam int RAT_CSB_LSB      = 0;   // 5 bits
  localparam int RAT_VCO_LSB      = 8;   // 5 bits
  localparam int RAT_LBIU_LSB     = 16;  // 2 bits
  localparam int UCM_I2C1_LSB     = 0;   // 2 bits of the unit clock register

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] UNIT_CLK_RESET  = 32'h0000_0000;
  localparam logic [1:0]  LBDIV_2         = 2'h0;
  localparam logic [1:0]  LBDIV_4         = 2'h1;
  localparam logic [1:0]  LBDIV_8         = 2'h2;
  localparam logic [1:0]  LB_RATIO_RESET  = LBDIV_2;
  localparam logic [3:0]  MULT_FIRST_OK   = 4'h2;  // Codes below are reserved
  localparam logic [1:0]  I2C2_FIXED_SEL  = 2'h0;
  localparam logic [1:0]  MEM_BEATS       = 2'h2;  // Transfers per memory clock

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       local_bus_clock_mode_bit;
    logic       memory_clock_mode_bit;
    logic [1:0] system_vco_divider_code;
    logic [3:0] system_pll_multiplier_code;
  } reset_config_word_low_s;

  typedef struct packed {
    logic       reserved_code;   // Multiplier code has no factor
    logic [4:0] csb_ratio;       // Bus clock over input clock
    logic [4:0] vco_multiple;    // VCO over bus clock
    logic [1:0] lbiu_ratio;      // Local bus unit over bus clock
  } clock_ratio_s;

endpackage

// ---- rtl/system_clock_ratio_config.sv ----
// System clock ratio decode, reset config capture and local bus clock divider
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

// Functional notes
// R1: Multiplier codes 0 and 1 are reserved; no factor, flagged reserved.
// R2: Multiplier codes 2..15 give input-to-bus ratio equal to the code.
// R3: Both mode bits clear: VCO equals bus clock times VCO divider.
// R4: Either mode bit set: VCO equals twice bus clock times divider.
// R5: Source must keep the VCO between 400 and 800 MHz.
// R6: VCO divider code 00/01/10/11 selects 4/8/2/1.
// R7: Halving strap high at reset doubles the bus clock ratio.
// R8: Reference is primary clock input as host, agent clock as agent.
// R9: Local bus unit clock is one or two times bus clock by mode bit.
// R10: External local bus clock is unit clock divided by 2, 4 or 8.
// R11: Memory interface moves two data beats per memory clock.
// R12: Software keeps security, USB, SATA, SD unit clocks at 200 MHz max.
// R13: Input clock and codes must keep bus clock within 133..400 MHz.
// R14: Only first serial two-wire controller has selectable clock source.
// R15: Config fields and strap latch at reset release, held until next reset.
module system_clock_ratio_config
  import clk_ratio_pkg::*;
#(
  parameter int ADDR_WIDTH = clk_ratio_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                                   CORE_CLK,
  input  wire logic                                   RST,
  // Reset configuration pins, asynchronous to the core clock
  input  wire clk_ratio_pkg::reset_config_word_low_s  RESET_CONFIG_WORD_LOW,
  input  wire logic                                   INPUT_CLOCK_HALVING_STRAP,
  input  wire logic                                   AGENT_MODE,
  // Register port
  input  wire logic [ADDR_WIDTH-1:0]                  REG_ADDR,
  input  wire logic [clk_ratio_pkg::DATA_W-1:0]       REG_WDATA,
  input  wire logic                                   REG_WR,
  input  wire logic                                   REG_RD,
  output logic      [clk_ratio_pkg::DATA_W-1:0]       REG_RDATA,
  // Clock plan outputs
  output clk_ratio_pkg::clock_ratio_s                 RATIO,
  output logic                                        REF_SELECT_AGENT,
  output logic                                        LCLK_EN,
  output logic      [clk_ratio_pkg::DATA_W-1:0]       UNIT_CLK_MODE,
  output logic      [1:0]                             I2C1_CLK_SEL,
  output logic      [1:0]                             I2C2_CLK_SEL,
  output logic      [1:0]                             MEM_BEATS_PER_CLK
);
  import clk_ratio_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_WIDTH < 4 || ADDR_WIDTH > 8) begin : g_bad_addr
    $error("ADDR_WIDTH must lie between 4 and 8");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers (no reset: data path only)
  // ----------------------------------------------------------------
  reset_config_word_low_s cfg_meta_reg;
  reset_config_word_low_s cfg_sync_reg;
  logic                   strap_meta_reg;
  logic                   strap_sync_reg;
  logic                   agent_meta_reg;
  logic                   agent_sync_reg;

  // Two stages; only the second stage feeds anything
  always_ff @(posedge CORE_CLK) begin
    cfg_meta_reg   <= RESET_CONFIG_WORD_LOW;
    cfg_sync_reg   <= cfg_meta_reg;
    strap_meta_reg <= INPUT_CLOCK_HALVING_STRAP;
    strap_sync_reg <= strap_meta_reg;
    agent_meta_reg <= AGENT_MODE;
    agent_sync_reg <= agent_meta_reg;
  end

  // ----------------------------------------------------------------
  // Reset capture
  // ----------------------------------------------------------------
  reset_config_word_low_s cfg_reg;
  logic                   strap_reg;
  logic                   agent_reg;

  // Track the pins while reset is held, freeze at release; a mid-run
  // pin change therefore cannot retune the clock plan
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_reg   <= cfg_sync_reg;    // R15
      strap_reg <= strap_sync_reg;  // R15
      agent_reg <= agent_sync_reg;  // R15
    end
  end

  // ----------------------------------------------------------------
  // Ratio decode
  // ----------------------------------------------------------------
  wire       mult_reserved = cfg_reg.system_pll_multiplier_code < MULT_FIRST_OK; // R1
  wire [4:0] mult_wide     = {1'b0, cfg_reg.system_pll_multiplier_code};
  wire [4:0] csb_ratio_w   = mult_reserved ? 5'h00 :            // R1
                             (strap_reg ? (mult_wide << 1) : mult_wide); // R2 R7
  wire       vco_double    = cfg_reg.memory_clock_mode_bit |
                             cfg_reg.local_bus_clock_mode_bit;
  wire [4:0] vco_div_w     = (cfg_reg.system_vco_divider_code == 2'h0) ? 5'h04 :
                             (cfg_reg.system_vco_divider_code == 2'h1) ? 5'h08 :
                             (cfg_reg.system_vco_divider_code == 2'h2) ? 5'h02 :
                                                                         5'h01; // R6
  wire [4:0] vco_mult_w    = vco_double ? (vco_div_w << 1) : vco_div_w; // R3 R4
  wire [1:0] lbiu_ratio_w  = cfg_reg.local_bus_clock_mode_bit ? 2'h2 : 2'h1; // R9

  // Plan outputs follow the frozen configuration
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RATIO            <= '0;
      REF_SELECT_AGENT <= 1'b0;
    end else begin
      RATIO.reserved_code <= mult_reserved;
      RATIO.csb_ratio     <= csb_ratio_w;
      RATIO.vco_multiple  <= vco_mult_w;
      RATIO.lbiu_ratio    <= lbiu_ratio_w;
      REF_SELECT_AGENT    <= agent_reg;  // R8
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire [7:0] addr_b    = 8'(REG_ADDR);
  wire       hit_sts   = addr_b == OFS_CFG_STATUS;
  wire       hit_rat   = addr_b == OFS_RATIO;
  wire       hit_ucm   = addr_b == OFS_UNIT_CLK;
  wire       hit_lbr   = addr_b == OFS_LB_RATIO;
  wire       wr_ucm    = REG_WR & hit_ucm;
  wire       wr_lbr    = REG_WR & hit_lbr;

  logic [31:0] unit_clk_reg;
  logic [1:0]  lb_div_reg;

  // Writable control: unit clock modes and local bus divide select.
  // Keeping the unit clocks legal is left to software.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      unit_clk_reg <= UNIT_CLK_RESET;
      lb_div_reg   <= LB_RATIO_RESET;
    end else begin
      if (wr_ucm) begin
        unit_clk_reg <= REG_WDATA;  // R12
      end
      if (wr_lbr) begin
        lb_div_reg <= (REG_WDATA[1:0] == 2'h3) ? LBDIV_8 : REG_WDATA[1:0]; // R10
      end
    end
  end

  wire [31:0] sts_word = (32'(cfg_reg) << STS_CFG_LSB) |
                         (32'(strap_reg) << STS_STRAP_BIT) |
                         (32'(agent_reg) << STS_AGENT_BIT) |
                         (32'(mult_reserved) << STS_RSVD_BIT);
  wire [31:0] rat_word = (32'(RATIO.csb_ratio) << RAT_CSB_LSB) |
                         (32'(RATIO.vco_multiple) << RAT_VCO_LSB) |
                         (32'(RATIO.lbiu_ratio) << RAT_LBIU_LSB);
  wire [31:0] rd_mux   = hit_sts ? sts_word :
                         hit_rat ? rat_word :
                         hit_ucm ? unit_clk_reg :
                         hit_lbr ? 32'(lb_div_reg) : 32'h0000_0000;

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      REG_RDATA <= '0;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Local bus clock enable divider
  // ----------------------------------------------------------------
  logic [2:0] lb_cnt_reg;
  wire  [2:0] lb_last = (lb_div_reg == LBDIV_2) ? 3'd1 :
                        (lb_div_reg == LBDIV_4) ? 3'd3 : 3'd7;
  wire        lb_wrap = lb_cnt_reg == lb_last;

  // A divide change restarts the count so no short period leaks out
  always_ff @(posedge CORE_CLK) begin
    if (RST || wr_lbr) begin
      lb_cnt_reg <= 3'd0;
      LCLK_EN    <= 1'b0;
    end else begin
      lb_cnt_reg <= lb_wrap ? 3'd0 : lb_cnt_reg + 3'd1;  // R10
      LCLK_EN    <= lb_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Register-driven and fixed outputs
  // ----------------------------------------------------------------
  assign UNIT_CLK_MODE     = unit_clk_reg;
  assign I2C1_CLK_SEL      = unit_clk_reg[UCM_I2C1_LSB +: 2];  // R14
  assign I2C2_CLK_SEL      = I2C2_FIXED_SEL;                   // R14
  assign MEM_BEATS_PER_CLK = MEM_BEATS;                        // R11

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic       live_reg;
  logic [3:0] gap_reg;
  always_ff @(posedge CORE_CLK) begin
    live_reg <= ~RST;
    // A restart clears the divider in the same cycle, while a pulse shows up
    // one cycle after the divider wrapped, so a restart starts one step early
    if (RST || wr_lbr) begin
      gap_reg <= 4'hF;
    end else if (LCLK_EN) begin
      gap_reg <= 4'd0;
    end else begin
      gap_reg <= gap_reg + 4'd1;
    end
  end

  sequence s_settled;
    live_reg ##1 live_reg;
  endsequence

  property p_reserved;
    @(posedge CORE_CLK) disable iff (RST)
      s_settled ##0 (cfg_reg.system_pll_multiplier_code < 4'h2) |->
        RATIO.reserved_code && RATIO.csb_ratio == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not flagged"); // R1

  property p_mult;
    @(posedge CORE_CLK) disable iff (RST)
      s_settled ##0 (!strap_reg && cfg_reg.system_pll_multiplier_code >= 4'h2) |->
        RATIO.csb_ratio == {1'b0, cfg_reg.system_pll_multiplier_code};
  endproperty
  a_mult: assert property (p_mult) else $error("bus ratio differs from code"); // R2

  property p_vco_plain;
    @(posedge CORE_CLK) disable iff (RST)
      s_settled ##0 (!cfg_reg.memory_clock_mode_bit && !cfg_reg.local_bus_clock_mode_bit)
        |-> RATIO.vco_multiple == vco_div_w;
  endproperty
  a_vco_plain: assert property (p_vco_plain) else $error("VCO multiple not divider"); // R3

  property p_vco_double;
    @(posedge CORE_CLK) disable iff (RST)
      s_settled ##0 (cfg_reg.memory_clock_mode_bit || cfg_reg.local_bus_clock_mode_bit)
        |-> RATIO.vco_multiple == 5'(vco_div_w * 2);
  endproperty
  a_vco_double: assert property (p_vco_double) else $error("VCO multiple not doubled"); // R4

  property p_vco_div;
    @(posedge CORE_CLK) disable iff (RST)
      s_settled ##0 !vco_double |->
        (cfg_reg.system_vco_divider_code == 2'h1) == (RATIO.vco_multiple == 5'h08) &&
        (cfg_reg.system_vco_divider_code == 2'h3) == (RATIO.vco_multiple == 5'h01);
  endproperty
  a_vco_div: assert property (p_vco_div) else $error("VCO divider decode wrong"); // R6

  property p_strap;
    @(posedge CORE_CLK) disable iff (RST)
      s_settled ##0 (strap_reg && !mult_reserved) |->
        RATIO.csb_ratio == 5'({1'b0, cfg_reg.system_pll_multiplier_code} * 2);
  endproperty
  a_strap: assert property (p_strap) else $error("strap did not double ratio"); // R7

  property p_ref;
    @(posedge CORE_CLK) disable iff (RST)
      s_settled |-> REF_SELECT_AGENT == agent_reg;
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong"); // R8

  property p_lbiu;
    @(posedge CORE_CLK) disable iff (RST)
      s_settled |-> RATIO.lbiu_ratio == (cfg_reg.local_bus_clock_mode_bit ? 2'h2 : 2'h1);
  endproperty
  a_lbiu: assert property (p_lbiu) else $error("local bus unit ratio wrong"); // R9

  property p_lclk;
    @(posedge CORE_CLK) disable iff (RST)
      LCLK_EN |-> gap_reg == 4'(lb_last);
  endproperty
  a_lclk: assert property (p_lclk) else $error("local bus clock period wrong"); // R10

  // A divide-by-2 write with no divider write in the two cycles behind it
  sequence s_fast_restart;
    wr_lbr ##1 (lb_div_reg == LBDIV_2 && !wr_lbr) ##1 !wr_lbr;
  endsequence

  property p_restart;
    @(posedge CORE_CLK) disable iff (RST)
      s_fast_restart |-> !LCLK_EN ##1 LCLK_EN;
  endproperty
  a_restart: assert property (p_restart) else $error("divider restart out of step"); // R10

  property p_hold;
    @(posedge CORE_CLK) disable iff (RST)
      live_reg |-> $stable(cfg_reg) && $stable(strap_reg) && $stable(agent_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed after reset"); // R15

  property p_i2c2;
    @(posedge CORE_CLK) disable iff (RST)
      wr_ucm |=> I2C2_CLK_SEL == 2'h0 && I2C1_CLK_SEL == $past(REG_WDATA[1:0]);
  endproperty
  a_i2c2: assert property (p_i2c2) else $error("serial clock select wrong"); // R14

endmodule

// ---- testbench/rcw_source_model.sv ----
// Model of the reset configuration word source feeding the strap pins
`timescale 1ns/100ps
module rcw_source_model
  import clk_ratio_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Settings commanded by the bench
  input  wire reset_config_word_low_s cmd_cfg,
  input  wire logic                   cmd_strap,
  input  wire logic                   cmd_agent,
  input  wire logic                   allow_reserved,
  // Pins toward the block
  output reset_config_word_low_s      cfg_pins = '0,
  output logic                        strap_pin = 1'b0,
  output logic                        agent_pin = 1'b0
);
  import clk_ratio_pkg::*;
  reset_config_word_low_s legal_cfg;

  // VCO over bus clock that the commanded divider and mode bits would give
  wire [4:0] vco_factor = ((cmd_cfg.system_vco_divider_code == 2'h0) ? 5'h04 :
                           (cmd_cfg.system_vco_divider_code == 2'h1) ? 5'h08 :
                           (cmd_cfg.system_vco_divider_code == 2'h2) ? 5'h02 : 5'h01)
                          << (cmd_cfg.memory_clock_mode_bit | cmd_cfg.local_bus_clock_mode_bit);
  // Some bus clock in 133..400 MHz must land the VCO in 400..800 MHz
  wire       window_ok  = (32'(vco_factor) * 133 <= 800) && (32'(vco_factor) * 400 >= 400);

  // Rule-breaking codes go out only when a scenario asks for them; an
  // out-of-window divider is steered to divide by 2, which always fits
  always_comb begin
    legal_cfg = cmd_cfg;
    if (!allow_reserved && cmd_cfg.system_pll_multiplier_code < 4'h2) begin
      legal_cfg.system_pll_multiplier_code = 4'h2;
    end
    if (!allow_reserved && !window_ok) begin
      legal_cfg.system_vco_divider_code = 2'h2;
    end
  end

  // Straps hold only during reset; after it the lines wander every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_pins  <= legal_cfg;
      strap_pin <= cmd_strap;
      agent_pin <= cmd_agent;
    end else begin
      cfg_pins  <= ~cfg_pins;
      strap_pin <= ~strap_pin;
      agent_pin <= ~agent_pin;
    end
  end
endmodule

// ---- testbench/system_clock_ratio_config_bench.sv ----
// Self-checking bench for the system clock ratio block
`timescale 1ns/100ps
module system_clock_ratio_config_bench;
  import clk_ratio_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [7:0]             addr = 8'h00;
  logic [31:0]            wdata = 32'h0000_0000, rdata, unit_mode;
  logic [31:0]            seed = 32'h0000_0060;
  logic [1:0]             i2c1_sel, i2c2_sel, beats, lbiu, stored;
  logic                   agent_ref, lclk_en, strap, agent;
  logic                   strap_cmd = 1'b0, agent_cmd = 1'b0, allow_rsv = 1'b0;
  logic [4:0]             csb, vco;
  reset_config_word_low_s rcw, rcw_cmd = '0, rcw_seen = '0;
  clock_ratio_s           ratio, ratio_exp;
  logic [31:0]            exp_q[$];
  int                     fails = 0, checks_done = 0, cycles = 0, n;

  system_clock_ratio_config dut (.CORE_CLK(clk), .RST(rst), .RESET_CONFIG_WORD_LOW(rcw),
    .INPUT_CLOCK_HALVING_STRAP(strap), .AGENT_MODE(agent), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RATIO(ratio), .REF_SELECT_AGENT(agent_ref),
    .LCLK_EN(lclk_en), .UNIT_CLK_MODE(unit_mode), .I2C1_CLK_SEL(i2c1_sel),
    .I2C2_CLK_SEL(i2c2_sel), .MEM_BEATS_PER_CLK(beats));
  rcw_source_model partner (.clk(clk), .rst(rst), .cmd_cfg(rcw_cmd), .cmd_strap(strap_cmd),
    .cmd_agent(agent_cmd), .allow_reserved(allow_rsv), .cfg_pins(rcw), .strap_pin(strap),
    .agent_pin(agent));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One strobe cycle; strobe stays up if another call follows at the next edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) exp_q.push_back(e);
  endtask

  // Waits for an enable pulse, bounded so a dead divider cannot hang the run
  task automatic wait_pulse();
    while (lclk_en !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and read monitor
  // ----------------------------------------------------------------
  initial forever #2 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    rd_d <= rd;
    if (cycles == 6000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always @(negedge clk) begin
    if (rd_d) check("read_data", rdata, exp_q.pop_front());
    else check("read_idle", rdata, 32'h0000_0000);
  end

  // ----------------------------------------------------------------
  // Main sequence: one reset round per multiplier code
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) begin
      seed = xorshift(seed);
      @(posedge clk);
      rcw_cmd <= {i[3], i[2], i[1:0], i[3:0]};
      strap_cmd <= seed[0];
      agent_cmd <= seed[1];
      allow_rsv <= (i < 2);
      rst <= 1'b1;
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (15) @(posedge clk);
      @(negedge clk);
      rcw_seen = rcw;  // Pins as the source strapped them, steering included
      check("rst_ratio", ratio, 32'h0000_0000);
      check("rst_lclk", lclk_en, 32'h0000_0000);
      @(posedge clk);
      rst <= 1'b0;
      // Expected clock plan worked out from the strapped settings
      csb = (i < 2) ? 5'h00 : 5'(i << strap_cmd);
      vco = (rcw_seen.system_vco_divider_code == 2'h0) ? 5'h04 :
            (rcw_seen.system_vco_divider_code == 2'h1) ? 5'h08 :
            (rcw_seen.system_vco_divider_code == 2'h2) ? 5'h02 : 5'h01;
      vco = vco << (rcw_seen.memory_clock_mode_bit | rcw_seen.local_bus_clock_mode_bit);
      lbiu = i[3] ? 2'h2 : 2'h1;
      stored = (i[1:0] == 2'h3) ? 2'h2 : i[1:0];
      ratio_exp = '{reserved_code: (i < 2), csb_ratio: csb, vco_multiple: vco, lbiu_ratio: lbiu};
      repeat (3) @(negedge clk);
      check("ratio", ratio, ratio_exp);
      check("ref_agent", agent_ref, agent_cmd);
      check("mem_beats", beats, 32'h0000_0002);
      check("i2c2_sel", i2c2_sel, 32'h0000_0000);
      // Back-to-back register traffic, a refused write and an unmapped read
      bus(1'b1, OFS_UNIT_CLK, seed, 32'h0000_0000);
      bus(1'b0, OFS_UNIT_CLK, 32'h0000_0000, seed);
      bus(1'b1, OFS_RATIO, ~seed, 32'h0000_0000);
      bus(1'b0, OFS_RATIO, 32'h0000_0000, {14'h0, lbiu, 3'h0, vco, 3'h0, csb});
      bus(1'b0, OFS_CFG_STATUS, 32'h0000_0000,
          {21'h0, i < 2, agent_cmd, strap_cmd, 8'(rcw_seen)});
      bus(1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000);
      bus(1'b1, OFS_LB_RATIO, {30'h0, i[1:0]}, 32'h0000_0000);
      bus(1'b0, OFS_LB_RATIO, 32'h0000_0000, {30'h0, stored});
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
      check("unit_mode", unit_mode, seed);
      check("i2c1_sel", i2c1_sel, {30'h0, seed[1:0]});
      // Gap between enable pulses follows the divide select
      n = 0;
      wait_pulse();
      @(negedge clk);
      n = 1;
      wait_pulse();
      check("lclk_gap", 32'(n), 32'(2 << stored));
      repeat (20) @(negedge clk);
      check("ratio_held", ratio, ratio_exp);
    end
    tally_and_finish();
  end
endmodule
